// File: rtl/clk_div_seq_pkg.sv
// Constants and state types shared by the clock divider sequencer.
// Assumes a single master clock domain; all pins except the asynchronous rst_b are sampled on mclk.
package clk_div_seq_pkg;

	localparam int RATIO_W    = 9;
	localparam int DIVCNT_W   = RATIO_W + 1;
	localparam int STAB_TICKS = 256;
	localparam int STAB_W     = 9;

	localparam logic [RATIO_W-1:0] RATIO_MAX = 9'h1ff;
	localparam logic [RATIO_W-1:0] RATIO_RST = 9'h000;
	localparam logic [DIVCNT_W-1:0] DIV_OFFSET = 10'h002;

	localparam logic RST_PIN_FUNC = 1'h1;
	localparam logic RST_REF_DIS  = 1'h1;
	localparam logic RST_PRE_SEL  = 1'h0;
	localparam logic RST_PRE_BYP  = 1'h1;
	localparam logic RST_DIV_BYP  = 1'h0;
	localparam logic RST_EXT_SEL  = 1'h0;

	typedef enum logic [3:0] {
		ST_POR, ST_PROG, ST_STAB, ST_REF_ON, ST_RUN,
		ST_DRAIN, ST_FLOAT, ST_STOP, ST_OFF
	} seq_state_t;

	typedef enum logic [2:0] {
		SRC_INT, SRC_HOLD_E, SRC_WAIT_E, SRC_EXT, SRC_HOLD_I
	} src_state_t;

endpackage

// File: rtl/programmable_clock_divider_sequencer.sv
// Clock reference mux, prescaler, divider and enabling sequencer.
// Assumes mclk is much faster than both reference clocks, which arrive
// as plain sampled inputs; stored settings come from nonvolatile memory.
//
// Notes on behaviour
// - Function bit 0: shared pin selects reference; 1: active-low power-down.
// - Reference disable bit 1 floats reference output; 0 drives master clock.
// - Divisor equals nine-bit ratio plus two, range 2 to 513.
// - Enable sampled on master rise; output starts one to two periods later.
// - A late enable change takes one more full master cycle.
// - Enable falling while output high lets the pulse finish, then low.
// - Late fall with output low yields one additional pulse.
// - Divide-by-one: one extra pulse on timely fall, two on late.
// - Select mode switches glitch-free; internal clock is prescaled oscillator.
// - Falling select seen on internal falling edge; output held low half period.
// - External clock routed only while low; otherwise wait for low.
// - Return to internal is level sensed, held low until internal fall.
// - Constantly high external clock blocks the return to internal.
// - Main output follows the same switching, divided by the divisor.
// - Function bit 1: pin high runs, pin low starts power-down.
// - Power-down: drain main, float it, stop master, float reference, osc off.
// - Power-up forces maximum ratios, waits 256 master cycles, then restores.
// - Power-on runs the same stabilisation and loads stored values.
// - Pull-up on the data pin at power-on enters programming mode.
// - Output enable low keeps main low and counters reset; osc runs.
// - Prescaler select 0 divides by 4, 1 by 2; bypass bits skip it.
// - Settings take effect only at power-up, never on the fly.
`timescale 1ns/1ps
`default_nettype none

module programmable_clock_divider_sequencer (
	input  wire logic                              mclk,
	input  wire logic                              rst_b,
	input  wire logic                              powerDownOrRefSelectPin,
	input  wire logic                              outputEnable,
	input  wire logic                              intOscIn,
	input  wire logic                              externalRefPin,
	input  wire logic                              progPullupSense,
	input  wire logic [clk_div_seq_pkg::RATIO_W-1:0] storedCountRatio,
	input  wire logic                              storedPinFunctionSelectBit,
	input  wire logic                              storedRefOutputDisableBit,
	input  wire logic                              storedPrescalerSel,
	input  wire logic                              storedPrescalerBypassBit,
	input  wire logic                              storedRatioBypassBit,
	input  wire logic                              storedExtSelect,
	output logic                                   mainClkOut,
	output logic                                   mainClkOe,
	output logic                                   referenceClockPin,
	output logic                                   referenceClockOe,
	output logic                                   oscEnable,
	output logic                                   extBufEnable,
	output logic                                   programMode
);
	import clk_div_seq_pkg::*;

	// ==============================================================
	// State declarations
	seq_state_t          seqState, next_seqState;
	src_state_t          srcState, next_srcState;
	logic [STAB_W-1:0]   stabCnt, next_stabCnt;
	logic [RATIO_W-1:0]  countRatioWord, next_countRatioWord;
	logic                pinFunctionSelectBit, next_pinFunctionSelectBit;
	logic                refOutputDisableBit, next_refOutputDisableBit;
	logic                prescalerSel, next_prescalerSel;
	logic                prescalerBypassBit, next_prescalerBypassBit;
	logic                ratioBypassBit, next_ratioBypassBit;
	logic                extSelect, next_extSelect;
	logic                next_programMode, next_mainClkOe;
	logic                next_referenceClockOe, next_oscEnable;
	logic                pinS1, pinS2, oscD, oscPrev, external_reference_clock;
	logic                internal_reference_clock, intPrev, preCnt, next_internal_reference_clock, next_preCnt;
	logic                masterClk, masterPrev, next_masterClk;
	logic                divRun, divOut, next_divRun, next_divOut;
	logic [DIVCNT_W-1:0] divCnt, next_divCnt, cntInc;
	logic                gate, next_gate, next_mainClkOut;
	logic                intRise, intFall, oscRise, masterRise;
	logic                wantInt, pdnReq, forceMax, masterRun;
	logic                mainAllowed, enSample, div1Mode, preBypass;
	logic [RATIO_W-1:0]  ratioEff;
	logic [DIVCNT_W-1:0] divisor, halfDiv;

	// Decoding of the running states, used by several outputs.
	function automatic logic refOnState(input seq_state_t s);
		return s == ST_REF_ON || s == ST_RUN || s == ST_DRAIN ||
			s == ST_FLOAT;
	endfunction

	assign intRise    = internal_reference_clock & ~intPrev;
	assign intFall    = ~internal_reference_clock & intPrev;
	assign oscRise    = oscD & ~oscPrev;
	assign masterRise = masterClk & ~masterPrev;
	assign wantInt  = pinFunctionSelectBit ? ~extSelect : pinS2;
	assign pdnReq   = pinFunctionSelectBit & ~pinS2;
	assign forceMax = seqState == ST_STAB;
	assign masterRun = seqState == ST_STAB || refOnState(seqState);
	assign mainAllowed = seqState == ST_RUN;
	assign enSample = outputEnable & mainAllowed;
	assign div1Mode = ratioBypassBit & ~forceMax;
	assign preBypass = ~forceMax & (prescalerBypassBit | ratioBypassBit);
	assign ratioEff = forceMax ? RATIO_MAX : countRatioWord;
	assign divisor  = {1'h0, ratioEff} + DIV_OFFSET;
	assign halfDiv  = divisor >> 1;
	assign cntInc   = (divCnt == divisor - 10'h001) ? '0 :
		divCnt + 10'h001;

	// ==============================================================
	// Clock path: prescaler, reference mux, divider and gating
	always_comb begin
		next_preCnt = preCnt;
		next_internal_reference_clock = internal_reference_clock;
		if (preBypass) begin
			next_internal_reference_clock = oscD;
		end else if (oscRise) begin
			if (forceMax || !prescalerSel) begin
				next_preCnt = ~preCnt;
				if (preCnt)
					next_internal_reference_clock = ~internal_reference_clock;
			end else begin
				next_internal_reference_clock = ~internal_reference_clock;
			end
		end

		// The mux only changes source while its output is held low,
		// so neither edge of either clock can be clipped.
		next_srcState = srcState;
		unique case (srcState)
			SRC_INT: begin
				if (!wantInt && intFall)
					next_srcState = SRC_HOLD_E;
			end
			SRC_HOLD_E: begin
				if (intRise)
					next_srcState = SRC_WAIT_E;
			end
			SRC_WAIT_E: begin
				if (wantInt)
					next_srcState = SRC_HOLD_I;
				else if (!external_reference_clock)
					next_srcState = SRC_EXT;
			end
			SRC_EXT: begin
				if (wantInt && !external_reference_clock)
					next_srcState = SRC_HOLD_I;
			end
			SRC_HOLD_I: begin
				if (intFall)
					next_srcState = SRC_INT;
			end
		endcase

		next_masterClk = 1'h0;
		if (masterRun && srcState == SRC_INT)
			next_masterClk = internal_reference_clock;
		else if (masterRun && srcState == SRC_EXT)
			next_masterClk = external_reference_clock;

		next_divRun = divRun;
		next_divCnt = divCnt;
		next_divOut = divOut;
		next_gate   = gate;
		if (masterRise) begin
			next_gate = enSample;
			if (!divRun) begin
				if (enSample && !div1Mode) begin
					next_divRun = 1'h1;
					next_divCnt = '0;
					next_divOut = 1'h1;
				end
			end else begin
				if (!enSample && !(cntInc < halfDiv)) begin
					next_divRun = 1'h0;
					next_divCnt = '0;
					next_divOut = 1'h0;
				end else begin
					next_divCnt = cntInc;
					next_divOut = cntInc < halfDiv;
				end
			end
		end

		// divided main output
		// In divide-by-one the gate is only consulted while the master is
		// low, so a gate change mid-pulse can never clip the pulse.
		if (div1Mode)
			next_mainClkOut = next_masterClk &
				(masterClk ? mainClkOut : gate);
		else
			next_mainClkOut = next_divOut;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pinS1             <= 1'h1;
			pinS2             <= 1'h1;
			oscD              <= 1'h0;
			oscPrev           <= 1'h0;
			external_reference_clock            <= 1'h0;
			internal_reference_clock            <= 1'h0;
			intPrev           <= 1'h0;
			preCnt            <= 1'h0;
			srcState          <= SRC_INT;
			masterClk         <= 1'h0;
			masterPrev        <= 1'h0;
			divRun            <= 1'h0;
			divCnt            <= '0;
			divOut            <= 1'h0;
			gate              <= 1'h0;
			mainClkOut        <= 1'h0;
			referenceClockPin <= 1'h0;
		end else begin
			pinS1             <= powerDownOrRefSelectPin;
			pinS2             <= pinS1;
			oscD              <= intOscIn & oscEnable;
			oscPrev           <= oscD;
			external_reference_clock            <= externalRefPin & extBufEnable;
			internal_reference_clock            <= next_internal_reference_clock;
			intPrev           <= internal_reference_clock;
			preCnt            <= next_preCnt;
			srcState          <= next_srcState;
			masterClk         <= next_masterClk;
			masterPrev        <= masterClk;
			divRun            <= next_divRun;
			divCnt            <= next_divCnt;
			divOut            <= next_divOut;
			gate              <= next_gate;
			mainClkOut        <= next_mainClkOut;
			referenceClockPin <= next_masterClk;
		end
	end

	// ==============================================================
	// Enabling sequencer and stored settings
	always_comb begin
		next_seqState             = seqState;
		next_stabCnt              = stabCnt;
		next_programMode          = programMode;
		next_countRatioWord       = countRatioWord;
		next_pinFunctionSelectBit = pinFunctionSelectBit;
		next_refOutputDisableBit  = refOutputDisableBit;
		next_prescalerSel         = prescalerSel;
		next_prescalerBypassBit   = prescalerBypassBit;
		next_ratioBypassBit       = ratioBypassBit;
		next_extSelect            = extSelect;
		unique case (seqState)
			ST_POR: begin
				if (progPullupSense) begin
					next_seqState    = ST_PROG;
					next_programMode = 1'h1;
				end else begin
					next_seqState = ST_STAB;
					next_stabCnt  = '0;
				end
			end
			ST_PROG: begin
			end
			ST_STAB: begin
				if (masterRise) begin
					next_stabCnt = stabCnt + 9'h001;
					if (stabCnt == STAB_W'(STAB_TICKS - 1)) begin
						next_seqState             = ST_REF_ON;
						next_countRatioWord       = storedCountRatio;
						next_pinFunctionSelectBit =
							storedPinFunctionSelectBit;
						next_refOutputDisableBit  =
							storedRefOutputDisableBit;
						next_prescalerSel         = storedPrescalerSel;
						next_prescalerBypassBit   =
							storedPrescalerBypassBit;
						next_ratioBypassBit       = storedRatioBypassBit;
						next_extSelect            = storedExtSelect;
					end
				end
			end
			ST_REF_ON: begin
				if (masterRise)
					next_seqState = ST_RUN;
			end
			ST_RUN: begin
				if (pdnReq)
					next_seqState = ST_DRAIN;
			end
			ST_DRAIN: begin
				if (!divRun && !gate && !mainClkOut)
					next_seqState = ST_FLOAT;
			end
			ST_FLOAT: begin
				// Stopping on a low master keeps the last pulse whole.
				if (!masterClk)
					next_seqState = ST_STOP;
			end
			ST_STOP: begin
				next_seqState = ST_OFF;
			end
			ST_OFF: begin
				if (!pdnReq) begin
					next_seqState = ST_STAB;
					next_stabCnt  = '0;
				end
			end
		endcase
		next_mainClkOe = next_seqState == ST_RUN ||
			next_seqState == ST_DRAIN;
		next_referenceClockOe = refOnState(next_seqState) &&
			!next_refOutputDisableBit;
		next_oscEnable = next_seqState == ST_STAB ||
			refOnState(next_seqState) || next_seqState == ST_STOP;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			seqState             <= ST_POR;
			stabCnt              <= '0;
			programMode          <= 1'h0;
			countRatioWord       <= RATIO_RST;
			pinFunctionSelectBit <= RST_PIN_FUNC;
			refOutputDisableBit  <= RST_REF_DIS;
			prescalerSel         <= RST_PRE_SEL;
			prescalerBypassBit   <= RST_PRE_BYP;
			ratioBypassBit       <= RST_DIV_BYP;
			extSelect            <= RST_EXT_SEL;
			mainClkOe            <= 1'h0;
			referenceClockOe     <= 1'h0;
			oscEnable            <= 1'h0;
			extBufEnable         <= 1'h0;
		end else begin
			seqState             <= next_seqState;
			stabCnt              <= next_stabCnt;
			programMode          <= next_programMode;
			countRatioWord       <= next_countRatioWord;
			pinFunctionSelectBit <= next_pinFunctionSelectBit;
			refOutputDisableBit  <= next_refOutputDisableBit;
			prescalerSel         <= next_prescalerSel;
			prescalerBypassBit   <= next_prescalerBypassBit;
			ratioBypassBit       <= next_ratioBypassBit;
			extSelect            <= next_extSelect;
			mainClkOe            <= next_mainClkOe;
			referenceClockOe     <= next_referenceClockOe;
			oscEnable            <= next_oscEnable;
			extBufEnable         <= next_oscEnable;
		end
	end

	// ==============================================================
	// Assertions
	a_fn_select: assert property (@(posedge mclk) disable iff (!rst_b)
		(seqState == ST_RUN && !pinFunctionSelectBit)
		|=> seqState != ST_DRAIN)
		else $error("Power-down started in select mode.");
	a_ref_disable: assert property (@(posedge mclk) disable iff (!rst_b)
		(refOutputDisableBit && $past(refOutputDisableBit))
		|-> !referenceClockOe)
		else $error("Reference output driven while disabled.");
	a_div_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
		(masterRise && divRun && outputEnable && mainAllowed &&
		divCnt == divisor - 10'h001) |=> divCnt == '0)
		else $error("Divider did not wrap at ratio plus two.");
	a_en_start: assert property (@(posedge mclk) disable iff (!rst_b)
		(masterRise && !divRun && enSample && !div1Mode)
		|=> divRun && divOut ##1 mainClkOut)
		else $error("Main output did not start after enable.");
	a_pulse_finish: assert property (@(posedge mclk) disable iff (!rst_b)
		(masterRise && divRun && divOut && cntInc < halfDiv)
		|=> divRun && divOut)
		else $error("High output pulse was truncated.");
	a_hold_low: assert property (@(posedge mclk) disable iff (!rst_b)
		(srcState == SRC_HOLD_E || srcState == SRC_WAIT_E)
		|=> !masterClk)
		else $error("Master clock not held low during switch.");
	a_ext_wait: assert property (@(posedge mclk) disable iff (!rst_b)
		(srcState == SRC_WAIT_E && external_reference_clock && !wantInt)
		|=> srcState == SRC_WAIT_E)
		else $error("External clock routed while high.");
	a_stab_len: assert property (@(posedge mclk) disable iff (!rst_b)
		(seqState == ST_STAB && masterRise &&
		stabCnt == STAB_W'(STAB_TICKS - 1)) |=> seqState == ST_REF_ON)
		else $error("Stabilisation wait has wrong length.");
	a_pd_float: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(seqState == ST_OFF) |-> !mainClkOe && !referenceClockOe
		&& $past(seqState) == ST_STOP)
		else $error("Power-down order broken.");

endmodule

`default_nettype wire

// File: dv/board_clock_partner.sv
// Board-side model of the clock sources feeding the divider sequencer.
// Assumes mclk is the bench master clock; sources change on its fall.
`timescale 1ns/1ps
`default_nettype none

module board_clock_partner #(
	parameter int HALF_INT = 3,
	parameter int HALF_EXT = 7
) (
	input  wire logic mclk,
	input  wire logic oscEnable,
	input  wire logic extStuckHigh,
	output logic      intOscIn,
	output logic      externalRefPin
);
	int oscCnt = 0;
	int extCnt = 0;

	initial begin
		intOscIn = 1'b0;
		externalRefPin = 1'b0;
	end

	// ==================================================================
	// Sources
	// The oscillator halts while disabled, so a powered-down source is
	// really still; the external reference runs free as a board part does.
	always @(negedge mclk) begin
		if (oscEnable === 1'b1) begin
			oscCnt = (oscCnt + 1) % HALF_INT;
			if (oscCnt == 0) begin
				intOscIn = ~intOscIn;
			end
		end
		extCnt = (extCnt + 1) % HALF_EXT;
		if (extCnt == 0) begin
			externalRefPin = extStuckHigh ? 1'b1 : ~externalRefPin;
		end
	end
endmodule

`default_nettype wire

// File: dv/programmable_clock_divider_sequencer_tb_top.sv
// Self-checking bench for the clock divider sequencer.
// Assumes the board partner makes a 6-cycle oscillator and 14-cycle ref.
`timescale 1ns/1ps
`default_nettype none

module programmable_clock_divider_sequencer_tb_top;
	import clk_div_seq_pkg::*;

	logic               mclk = 1'b0;
	logic               rst_b = 1'b0;
	logic               pin = 1'b1;
	logic               outputEnable = 1'b0;
	logic               progPullupSense = 1'b0;
	logic               extStuckHigh = 1'b0;
	logic [RATIO_W-1:0] storedCountRatio = 9'h000;
	logic               fnBit = 1'b1;
	logic               refDis = 1'b1;
	logic               preSel = 1'b0;
	logic               preByp = 1'b1;
	logic               divByp = 1'b0;
	logic               extSel = 1'b0;
	logic               probeSel = 1'b0;
	wire logic          intOscIn, externalRefPin, mainClkOut, mainClkOe;
	wire logic          referenceClockPin, referenceClockOe, oscEnable;
	wire logic          extBufEnable, programMode, probe;
	int                 nErrors = 0;
	int                 nTests = 0;

	assign probe = probeSel ? referenceClockPin : mainClkOut;

	always #10 mclk = ~mclk;

	programmable_clock_divider_sequencer programmable_clock_divider_sequencer_inst (
		.mclk(mclk), .rst_b(rst_b), .powerDownOrRefSelectPin(pin),
		.outputEnable(outputEnable), .intOscIn(intOscIn),
		.externalRefPin(externalRefPin), .progPullupSense(progPullupSense),
		.storedCountRatio(storedCountRatio),
		.storedPinFunctionSelectBit(fnBit),
		.storedRefOutputDisableBit(refDis), .storedPrescalerSel(preSel),
		.storedPrescalerBypassBit(preByp), .storedRatioBypassBit(divByp),
		.storedExtSelect(extSel), .mainClkOut(mainClkOut),
		.mainClkOe(mainClkOe), .referenceClockPin(referenceClockPin),
		.referenceClockOe(referenceClockOe), .oscEnable(oscEnable),
		.extBufEnable(extBufEnable), .programMode(programMode));

	board_clock_partner board_clock_partner_inst (
		.mclk(mclk), .oscEnable(oscEnable), .extStuckHigh(extStuckHigh),
		.intOscIn(intOscIn), .externalRefPin(externalRefPin));

	// ==================================================================
	// Shared tasks
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			nErrors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// Period and high time of the probed output, in master cycles.
	task automatic measure(input logic useRef, output int per, output int hi);
		int t;
		probeSel = useRef;
		cyc(1);
		t = 0;
		while (probe !== 1'b0 && t < 4000) begin cyc(1); t++; end
		while (probe !== 1'b1 && t < 8000) begin cyc(1); t++; end
		hi = 0;
		while (probe === 1'b1 && hi < 4000) begin cyc(1); hi++; end
		per = hi;
		while (probe === 1'b0 && per < 8000) begin cyc(1); per++; end
	endtask

	// Shortest run between reference transitions; a runt shows as small.
	task automatic minRun(input int n, output int mn);
		int run;
		logic prev;
		logic seenEdge;
		mn = 1000;
		run = 0;
		prev = referenceClockPin;
		seenEdge = 1'b0;
		repeat (n) begin
			cyc(1);
			run++;
			if (referenceClockPin !== prev) begin
				if (seenEdge && run < mn) mn = run;
				seenEdge = 1'b1;
				run = 0;
				prev = referenceClockPin;
			end
		end
	endtask

	// Settings are presented before reset so the stabilisation loads them.
	task automatic powerUp(input logic [RATIO_W-1:0] r, input logic [5:0] cfg);
		int t;
		{fnBit, refDis, preSel, preByp, divByp, extSel} = cfg;
		storedCountRatio = r;
		rst_b = 1'b0;
		cyc(16);
		check(16'({mainClkOe, referenceClockOe, oscEnable}), 16'h0);
		rst_b = 1'b1;
		t = 0;
		while (mainClkOe !== 1'b1 && t < 9000) begin cyc(1); t++; end
		check(16'(t >= STAB_TICKS * 6 && t < 8500), 16'h1);
		check(16'(oscEnable), 16'h1);
		outputEnable = 1'b1;
		cyc(100);
	endtask

	// ==================================================================
	// Scenarios
	task automatic test_prog();
		progPullupSense = 1'b1;
		rst_b = 1'b0;
		cyc(16);
		rst_b = 1'b1;
		cyc(300);
		check(16'({programMode, mainClkOe, oscEnable}), 16'h4);
		progPullupSense = 1'b0;
		$display("test_prog done");
	endtask

	task automatic test_ratio(input logic [RATIO_W-1:0] r,
			input logic [5:0] cfg, input int expPer, input int expHi);
		int per;
		int hi;
		powerUp(r, cfg);
		check(16'(referenceClockOe), 16'(!cfg[4]));
		measure(1'b0, per, hi);
		check(16'(per), 16'(expPer));
		check(16'(hi), 16'(expHi));
		if (cfg[1]) begin
			while (mainClkOut !== 1'b0) cyc(1);
			outputEnable = 1'b0;
			hi = 0;
			repeat (60) begin
				cyc(1);
				if (mainClkOut === 1'b1) hi++;
			end
			check(16'(hi), 16'(expHi));
			outputEnable = 1'b1;
		end
		$display("test_ratio %h done", r);
	endtask

	task automatic test_no_fly();
		int per;
		int hi;
		storedCountRatio = 9'h005;
		preByp = 1'b0;
		cyc(50);
		measure(1'b0, per, hi);
		check(16'(per), 16'd28);
		$display("test_no_fly done");
	endtask

	task automatic test_enable();
		int t;
		int per;
		int hi;
		logic seen;
		powerUp(9'h003, 6'b101000);
		probeSel = 1'b0;
		measure(1'b0, per, hi);
		while (mainClkOut !== 1'b1) cyc(1);
		cyc(5);
		outputEnable = 1'b0;
		t = 5;
		while (mainClkOut === 1'b1 && t < 500) begin cyc(1); t++; end
		check(16'(t), 16'd24);
		seen = 1'b0;
		repeat (200) begin cyc(1); seen |= mainClkOut; end
		check(16'(seen), 16'h0);
		measure(1'b1, per, hi);
		check(16'(per), 16'd12);
		outputEnable = 1'b1;
		t = 0;
		while (mainClkOut !== 1'b1 && t < 500) begin cyc(1); t++; end
		check(16'(t <= 2 * 12 + 2), 16'h1);
		$display("test_enable done");
	endtask

	task automatic test_powerdown();
		int tm = -1;
		int tr = -1;
		int to = -1;
		int t;
		int per;
		int hi;
		logic lowAtFloat = 1'b1;
		powerUp(9'h003, 6'b101000);
		pin = 1'b0;
		for (int i = 0; i < 3000; i++) begin
			cyc(1);
			if (mainClkOe !== 1'b1 && tm < 0) begin
				tm = i;
				lowAtFloat = mainClkOut;
			end
			if (referenceClockOe !== 1'b1 && tr < 0) tr = i;
			if (oscEnable !== 1'b1 && to < 0) to = i;
		end
		check(16'(lowAtFloat), 16'h0);
		check(16'(tm >= 0 && tm < tr && tr < to), 16'h1);
		check(16'(extBufEnable), 16'h0);
		pin = 1'b1;
		t = 0;
		while (mainClkOe !== 1'b1 && t < 9000) begin cyc(1); t++; end
		check(16'(t >= STAB_TICKS * 6 && t < 8500), 16'h1);
		measure(1'b0, per, hi);
		check(16'(per), 16'd60);
		$display("test_powerdown done");
	endtask

	task automatic test_select();
		int per;
		int hi;
		int mn;
		int edges;
		logic prev;
		powerUp(9'h000, 6'b000100);
		measure(1'b1, per, hi);
		check(16'(per), 16'd6);
		pin = 1'b0;
		minRun(150, mn);
		check(16'(mn >= 3), 16'h1);
		check(16'(mainClkOe), 16'h1);
		measure(1'b1, per, hi);
		check(16'(per), 16'd14);
		measure(1'b0, per, hi);
		check(16'(per), 16'd28);
		pin = 1'b1;
		minRun(150, mn);
		check(16'(mn >= 3), 16'h1);
		measure(1'b1, per, hi);
		check(16'(per), 16'd6);
		pin = 1'b0;
		cyc(150);
		// The reference must already sit high when the select returns.
		extStuckHigh = 1'b1;
		cyc(20);
		pin = 1'b1;
		cyc(50);
		edges = 0;
		prev = referenceClockPin;
		repeat (300) begin
			cyc(1);
			if (referenceClockPin !== prev) edges++;
			prev = referenceClockPin;
		end
		check(16'(edges), 16'h0);
		extStuckHigh = 1'b0;
		cyc(100);
		measure(1'b1, per, hi);
		check(16'(per), 16'd6);
		$display("test_select done");
	endtask

	// ==================================================================
	// Sequence and watchdog
	initial begin
		test_prog();
		test_ratio(9'h000, 6'b100100, 12, 6);
		test_ratio(9'h1ff, 6'b110100, 3078, 1536);
		test_ratio(9'h003, 6'b101000, 60, 24);
		test_ratio(9'h001, 6'b100000, 72, 24);
		test_ratio(9'h000, 6'b100010, 6, 3);
		test_ratio(9'h000, 6'b100101, 28, 14);
		test_no_fly();
		test_enable();
		test_powerdown();
		test_select();
		tally_and_finish();
	end

	// Ten stabilisations of about 6k cycles plus measurements fit here.
	initial begin
		#1900000;
		nErrors++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
